// [ppr_params.svh]
// Constants for the priority pause request block.
// Included by the package and design modules; definitions only.
`ifndef PPR_PARAMS_SVH
`define PPR_PARAMS_SVH
`define PPR_NUM_CLASSES  8
`define PPR_QUANTA_W     16
`define PPR_QUANTUM_BITS 512
// Cycles per pause quantum at 8 bits per user clock cycle
`define PPR_QUANTUM_CYC  (`PPR_QUANTUM_BITS / 8)
`define PPR_QCNT_W       6
`define PPR_QUANTA_RST   16'h0000
`endif

// [ppr_pkg.sv]
// Types shared by the priority pause request block.
// Assumes ppr_params.svh is on the include path.
`include "ppr_params.svh"
package ppr_pkg;
  typedef logic [`PPR_QUANTA_W-1:0]     ppr_quanta_type;
  typedef logic [`PPR_NUM_CLASSES-1:0]  ppr_class_mask_type;
  typedef enum logic [1:0] {PPR_TX_IDLE, PPR_TX_WAIT_EOF, PPR_TX_SEND} ppr_tx_state_type;
endpackage

// [ppr_rx_class.sv]
// One receive class: holds captured quanta until acknowledged, then expires them.
// Assumes capture strobes and quantum tick come from the same clock domain.
`timescale 1ns/1ns
`default_nettype none
`include "ppr_params.svh"
module ppr_rx_class
  import ppr_pkg::*;
(
  // Clock and reset
  input  wire logic           sys_clk_i,
  input  wire logic           rst_i,
  // Capture from receive parser, quantum tick from timebase
  input  wire logic           cap_valid_i,
  input  wire ppr_quanta_type cap_quanta_i,
  input  wire logic           quantum_tick_i,
  // Class receive FIFO
  input  wire logic           ack_i,
  output logic                ind_o,
  output ppr_quanta_type      quanta_o
);
  ppr_quanta_type quanta_reg;
  logic           running_reg;

  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      quanta_reg <= `PPR_QUANTA_RST;
    end else if (cap_valid_i) begin
      quanta_reg <= cap_quanta_i;
    end else if (running_reg && quantum_tick_i && quanta_reg != '0) begin
      quanta_reg <= quanta_reg - 16'h0001;
    end
  end

  // Countdown armed only once the FIFO has acknowledged
  always_ff @(posedge sys_clk_i) begin
    if (rst_i || cap_valid_i) begin
      running_reg <= 1'b0;
    end else if (ind_o && ack_i) begin
      running_reg <= 1'b1;
    end
  end

  assign ind_o    = (quanta_reg != '0);
  assign quanta_o = quanta_reg;
endmodule // ppr_rx_class
`default_nettype wire

// [ppr_top.sv]
// Priority pause request ports of the MAC: eight class channels.
// Assumes MAC user clock, synchronous reset, same-domain client FIFOs.
//
// Summary of operation
// - These ports are always present; they act only when the build parameter enables priority pause support.
// - Eight independent request channels exist, one per class 0 to 7.
// - A transmit pause request of a class yields a priority pause frame for it next possible.
// - A receive pause indication per class is driven toward that class's receive FIFO.
// - Captured quanta of a class are not counted down before that FIFO acknowledges.
// - A pause frame starts only after the current data frame has completed.
`timescale 1ns/1ns
`default_nettype none
`include "ppr_params.svh"
module ppr_top
  import ppr_pkg::*;
#(
  parameter bit PFC_ENABLE = 1'b1
)(
  // Clock and reset
  input  wire logic                     sys_clk_i,
  input  wire logic                     rst_i,
  // Transmit pause requests, one per class
  input  wire logic [7:0]               tx_prio_pause_req_i,
  // Transmit engine status
  input  wire logic                     tx_frame_busy_i,
  input  wire logic                     tx_pause_done_i,
  output logic                          tx_pause_start_o,
  output ppr_class_mask_type            tx_pause_classes_o,
  // Received priority pause frames
  input  wire logic                     rx_pause_valid_i,
  input  wire ppr_class_mask_type       rx_pause_classes_i,
  input  wire logic [8*`PPR_QUANTA_W-1:0] rx_pause_quanta_i,
  // Receive FIFO pause signalling
  input  wire logic [7:0]               rx_prio_pause_ack_i,
  output logic [7:0]                    rx_prio_pause_ind_o
);
  // Three parts share one clock and one reset:
  //   transmit scheduler gathering class requests into one pause frame,
  //   free-running timebase ticking once per pause quantum,
  //   eight receive channels holding captured quanta until they expire.
  // Client FIFOs share this clock domain, so no input is synchronised.

  // Feature switch and gated requests
  logic                   pfc_on;
  logic                   rx_rst;
  logic [7:0]             req_w;

  // Transmit scheduler
  ppr_tx_state_type       state_reg;
  ppr_class_mask_type     pend_reg;
  ppr_class_mask_type     sent_reg;
  logic                   take_pend;
  logic                   done_w;
  logic                   start_w;

  // Quantum timebase
  logic [`PPR_QCNT_W-1:0] qcnt_reg;
  logic                   tick;

  // Receive side, one entry per class
  logic [7:0]             cap_w;
  ppr_quanta_type         cap_quanta_w [`PPR_NUM_CLASSES];
  logic [7:0]             ind_w;

  // Build-time feature switch
  // Off: requests never reach the scheduler and every receive channel stays in reset
  generate
    if (PFC_ENABLE) begin : g_pfc_on
      assign pfc_on              = 1'b1;
      assign req_w               = tx_prio_pause_req_i;
      assign rx_prio_pause_ind_o = ind_w;
    end else begin : g_pfc_off
      assign pfc_on              = 1'b0;
      assign req_w               = 8'h00;
      assign rx_prio_pause_ind_o = 8'h00;
    end
  endgenerate
  assign rx_rst = rst_i || !pfc_on;

  // Quantum timebase: free running, one tick per pause quantum
  // A fresh countdown may therefore see its first tick early
  always_ff @(posedge sys_clk_i) begin
    if (rst_i || tick) begin
      qcnt_reg <= '0;
    end else begin
      qcnt_reg <= qcnt_reg + 6'h01;
    end
  end
  assign tick = (qcnt_reg == 6'(`PPR_QUANTUM_CYC - 1));

  // Hand-over of pending classes; done counts only while sending
  assign take_pend = (state_reg == PPR_TX_IDLE) && (pend_reg != '0);
  assign done_w    = (state_reg == PPR_TX_SEND) && tx_pause_done_i;

  // Scheduler: wait for the wire to go free, then hand the frame over
  // Requests arriving meanwhile wait for the following frame
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      state_reg <= PPR_TX_IDLE;
    end else begin
      unique case (state_reg)
        PPR_TX_IDLE: begin
          if (take_pend) begin
            state_reg <= PPR_TX_WAIT_EOF;
          end
        end
        PPR_TX_WAIT_EOF: begin
          if (!tx_frame_busy_i) begin
            state_reg <= PPR_TX_SEND;
          end
        end
        PPR_TX_SEND: begin
          if (done_w) begin
            state_reg <= PPR_TX_IDLE;
          end
        end
        default: begin
          state_reg <= PPR_TX_IDLE;
        end
      endcase
    end
  end

  // Start only once the current data frame has left the wire
  assign start_w            = (state_reg == PPR_TX_WAIT_EOF) && !tx_frame_busy_i;
  assign tx_pause_start_o   = start_w;
  assign tx_pause_classes_o = sent_reg;

  // Per-class channels: transmit pending bit, frame class bit, receive pause
  genvar g;
  generate
    for (g = 0; g < `PPR_NUM_CLASSES; g++) begin : g_cls
      logic pend_bit_reg;
      logic sent_bit_reg;

      // Pending request; a request in the hand-over cycle stays pending
      always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin
          pend_bit_reg <= 1'b0;
        end else if (take_pend) begin
          pend_bit_reg <= req_w[g];
        end else if (req_w[g]) begin
          pend_bit_reg <= 1'b1;
        end
      end

      // Class bit of the frame, held until the next hand-over
      always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin
          sent_bit_reg <= 1'b0;
        end else if (take_pend) begin
          sent_bit_reg <= pend_bit_reg;
        end
      end

      assign pend_reg[g] = pend_bit_reg;
      assign sent_reg[g] = sent_bit_reg;

      // Receive channel: capture strobe and quanta slice of this class
      assign cap_w[g]        = rx_pause_valid_i && rx_pause_classes_i[g];
      assign cap_quanta_w[g] = rx_pause_quanta_i[g*`PPR_QUANTA_W +: `PPR_QUANTA_W];
      ppr_rx_class u_cls (
        .sys_clk_i      (sys_clk_i),
        .rst_i          (rx_rst),
        .cap_valid_i    (cap_w[g]),
        .cap_quanta_i   (cap_quanta_w[g]),
        .quantum_tick_i (tick),
        .ack_i          (rx_prio_pause_ack_i[g]),
        .ind_o          (ind_w[g]),
        .quanta_o       ()
      );
    end
  endgenerate
endmodule // ppr_top
`default_nettype wire

// [ppr_top_chk.sv]
// Port checker for ppr_top, class 2 stands for all receive classes.
// Assumes a bind from the testbench and the ppr_pkg types.
`timescale 1ns/1ns
`default_nettype none
module ppr_top_chk
  import ppr_pkg::*;
(
  // Observed ports
  input wire logic               sys_clk_i,
  input wire logic               rst_i,
  input wire logic               tx_frame_busy_i,
  input wire logic               tx_pause_done_i,
  input wire logic               tx_pause_start_o,
  input wire ppr_class_mask_type tx_pause_classes_o,
  input wire logic               rx_pause_valid_i,
  input wire ppr_class_mask_type rx_pause_classes_i,
  input wire logic [127:0]       rx_pause_quanta_i,
  input wire logic [7:0]         rx_prio_pause_ack_i,
  input wire logic [7:0]         rx_prio_pause_ind_o
);
  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (rst_i);
  wire logic cap2 = rx_pause_valid_i && rx_pause_classes_i[2];
  wire logic q2   = rx_pause_quanta_i[47:32] != 16'h0000;
  // Capture, then eight cycles with no acknowledge
  sequence s_cap_unacked;
    cap2 && q2 ##1 (!rx_prio_pause_ack_i[2] && !rx_pause_valid_i)[*8];
  endsequence
  AST_NO_CUT: assert property (tx_pause_start_o |-> !tx_frame_busy_i) else $error("cut");
  AST_START_ONE: assert property (tx_pause_start_o |=> !tx_pause_start_o) else $error("st");
  AST_DONE_IDLE: assert property (tx_pause_done_i |=> !tx_pause_start_o) else $error("dn");
  AST_CLS_SET: assert property (tx_pause_start_o |-> tx_pause_classes_o != 8'h00) else $error("cls");
  AST_IND_CAP: assert property (cap2 && q2 |=> rx_prio_pause_ind_o[2]) else $error("ind");
  AST_HOLD: assert property (s_cap_unacked |-> rx_prio_pause_ind_o[2]) else $error("hold");
  AST_ZERO: assert property (cap2 && !q2 |=> !rx_prio_pause_ind_o[2]) else $error("zero");
  AST_IND_STAY: assert property (rx_prio_pause_ind_o[2] && !rx_prio_pause_ack_i[2] && !cap2
    |=> rx_prio_pause_ind_o[2] || $past(rx_prio_pause_ack_i[2], 1)) else $error("st2");
endmodule // ppr_top_chk
`default_nettype wire

// [ppr_fifo_model.sv]
// Receive FIFO model: acknowledges a pause some cycles after it starts.
// Assumes one class paused at a time, same clock as ppr_top.
`timescale 1ns/1ns
`default_nettype none
module ppr_fifo_model (
  // Pause signalling
  input  wire logic       sys_clk_i,
  input  wire logic [7:0] ind_i,
  input  wire logic [7:0] tied_i,
  input  wire logic [3:0] delay_i,
  output logic      [7:0] ack_o
);
  logic [3:0] wait_reg;
  always_ff @(posedge sys_clk_i)
    wait_reg <= (ind_i != 8'h00) ? wait_reg + 4'(wait_reg != 4'hf) : 4'h0;
  assign ack_o = tied_i | (ind_i & {8{wait_reg >= delay_i}});
endmodule // ppr_fifo_model
`default_nettype wire

// [testbench.sv]
// Testbench: ppr_top against the FIFO model, checker bound below.
// Assumes package, checker and model are compiled first.
`timescale 1ns/1ns
`default_nettype none
module testbench;
  logic         sys_clk_i = 0, rst_i = 1, busy = 0, done = 0, rv = 0, start;
  logic [7:0]   req = 0, rc = 0, ack, ind, cls, tied = 0;
  logic [3:0]   dly = 0;
  logic [127:0] rq = 0;
  int           n_fail, n_compared, cyc;
  ppr_top i_ppr_top (.sys_clk_i, .rst_i, .tx_prio_pause_req_i(req), .tx_frame_busy_i(busy),
    .tx_pause_done_i(done), .tx_pause_start_o(start), .tx_pause_classes_o(cls),
    .rx_pause_valid_i(rv), .rx_pause_classes_i(rc), .rx_pause_quanta_i(rq),
    .rx_prio_pause_ack_i(ack), .rx_prio_pause_ind_o(ind));
  ppr_fifo_model i_ppr_fifo_model (.sys_clk_i, .ind_i(ind), .tied_i(tied), .delay_i(dly),
    .ack_o(ack));
  initial forever #10 sys_clk_i = ~sys_clk_i;
  task chk(string nm, logic [7:0] e, logic [7:0] g);
    n_compared++;
    if (g !== e) n_fail++;
    if (g !== e) $display("wrong value %s exp %h got %h", nm, e, g);
  endtask
  task give_verdict;
    $display("compared %0d failed %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  always @(posedge sys_clk_i) begin
    cyc++;
    if (cyc == 3000) n_fail++;
    if (cyc == 3000) give_verdict;
  end
  // Request during a busy frame, frame starts once the wire is free
  task test_tx(int k);
    busy = 1;
    req = 8'h01 << k;
    @(negedge sys_clk_i) req = 0;
    repeat (3) @(negedge sys_clk_i) chk("start", 0, {7'h0, start});
    busy = 0;
    #1 chk("start", 1, {7'h0, start});
    chk("classes", 8'h01 << k, cls);
    @(negedge sys_clk_i) done = 1;
    @(negedge sys_clk_i) done = 0;
    $display("tx class %0d over", k);
  endtask
  // Capture quanta, count cycles the indication stands; delay 0 ties ack high
  task test_rx(int k, logic [15:0] q, logic [3:0] d, logic [7:0] lo, logic [7:0] hi);
    logic [7:0] c;
    dly = d;
    tied = (d == 4'h0) ? 8'hff : 8'h00;
    rv = 1;
    rc = 8'h01 << k;
    rq = {112'h0, q} << (16 * k);
    @(negedge sys_clk_i) rv = 0;
    chk("ind", (q != 16'h0) ? 8'h01 << k : 8'h00, ind);
    for (c = 0; ind[k] === 1'b1 && c < hi; c++) @(negedge sys_clk_i);
    chk("hold", 1, {7'h0, c >= lo && c < hi});
    $display("rx class %0d over", k);
  endtask
  initial begin
    repeat (10) @(negedge sys_clk_i);
    rst_i = 0;
    chk("ind", 0, ind);
    for (int k = 0; k < 8; k++) test_tx(k);
    test_rx(2, 16'h0001, 4'hf, 16, 83);
    test_rx(5, 16'h0002, 4'h5, 64, 145);
    test_rx(0, 16'h0001, 4'h0, 1, 66);
    test_rx(2, 16'h0000, 4'h3, 0, 1);
    give_verdict;
  end
endmodule // testbench
bind ppr_top ppr_top_chk i_ppr_top_chk (.sys_clk_i, .rst_i, .tx_frame_busy_i,
  .tx_pause_done_i, .tx_pause_start_o, .tx_pause_classes_o, .rx_pause_valid_i, .rx_pause_classes_i,
  .rx_pause_quanta_i, .rx_prio_pause_ack_i, .rx_prio_pause_ind_o);
`default_nettype wire
